/* File: verilog/acm_entry_matcher.sv */
`timescale 1ns/1ps
`default_nettype none
module acm_entry_matcher #(
  parameter int COUNT_W = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata_q,
  input wire logic frm_valid,
  input wire logic frm_is_ipv4,
  input wire logic frm_is_arp,
  input wire logic [7:0] frm_ip_proto,
  input wire logic [7:0] frm_ttl,
  input wire logic frm_more_frags,
  input wire logic [12:0] frm_frag_offset,
  input wire logic frm_has_options,
  input wire logic [31:0] frm_source_ip_address,
  input wire logic [31:0] frm_destination_ip_address,
  input wire logic [47:0] frm_source_mac_address,
  input wire logic [47:0] frm_destination_mac_address,
  input wire logic [11:0] frm_vid,
  input wire logic [2:0] frm_pcp,
  output logic hit_valid_q,
  output logic hit_q,
  output logic [2:0] l4_sel_q
);
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
    $error("acm_entry_matcher: COUNT_W must be 1..32");
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [acm_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0] proto_val_q;
  logic [2:0] pcp_val_q;
  logic [11:0] vid_val_q;
  logic [31:0] sip_q;
  logic [31:0] sip_mask_q;
  logic [31:0] dip_q;
  logic [31:0] dip_mask_q;
  logic [47:0] source_mac_address_q;
  logic [47:0] destination_mac_address_q;
  logic [COUNT_W-1:0] frames_q;
  logic [COUNT_W-1:0] hits_q;
  logic last_ipv4_q;
  logic seen_q;

  logic [1:0] ftype_m, ttl_m, frag_m, opt_m, sip_m, dip_m;
  logic [2:0] proto_m, destination_mac_address_m;
  logic source_mac_address_m, vid_m, pcp_m;
  logic [11:0] wr_vid;

  assign ftype_m = ctrl_q[acm_pkg::POS_FTYPE +: 2];
  assign proto_m = ctrl_q[acm_pkg::POS_PROTO +: 3];
  assign ttl_m = ctrl_q[acm_pkg::POS_TTL +: 2];
  assign frag_m = ctrl_q[acm_pkg::POS_FRAG +: 2];
  assign opt_m = ctrl_q[acm_pkg::POS_OPT +: 2];
  assign sip_m = ctrl_q[acm_pkg::POS_SIP +: 2];
  assign dip_m = ctrl_q[acm_pkg::POS_DIP +: 2];
  assign source_mac_address_m = ctrl_q[acm_pkg::POS_SOURCE_MAC_ADDRESS];
  assign destination_mac_address_m = ctrl_q[acm_pkg::POS_DESTINATION_MAC_ADDRESS +: 3];
  assign vid_m = ctrl_q[acm_pkg::POS_VID];
  assign pcp_m = ctrl_q[acm_pkg::POS_PCP];
  assign wr_vid = bus_wdata[acm_pkg::POS_VID_VAL +: 12];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= acm_pkg::RST_CTRL;
      proto_val_q <= acm_pkg::RST_PROTO_VAL;
      pcp_val_q <= acm_pkg::RST_PCP_VAL;
      vid_val_q <= acm_pkg::RST_VID_VAL;
      sip_q <= acm_pkg::RST_IP;
      sip_mask_q <= acm_pkg::RST_IP;
      dip_q <= acm_pkg::RST_IP;
      dip_mask_q <= acm_pkg::RST_IP;
      source_mac_address_q <= acm_pkg::RST_MAC;
      destination_mac_address_q <= acm_pkg::RST_MAC;
    end else if (bus_wr) begin
      case (bus_addr)
        acm_pkg::OFS_CTRL: ctrl_q <= bus_wdata[acm_pkg::CTRL_W-1:0];
        acm_pkg::OFS_MATCH: begin
          proto_val_q <= bus_wdata[acm_pkg::POS_PROTO_VAL +: 8];
          pcp_val_q <= bus_wdata[acm_pkg::POS_PCP_VAL +: 3];
          if (wr_vid != acm_pkg::VID_NONE) begin
            vid_val_q <= wr_vid;
          end
        end
        acm_pkg::OFS_SIP: sip_q <= bus_wdata;
        acm_pkg::OFS_SIP_MASK: sip_mask_q <= bus_wdata;
        acm_pkg::OFS_DIP: dip_q <= bus_wdata;
        acm_pkg::OFS_DIP_MASK: dip_mask_q <= bus_wdata;
        acm_pkg::OFS_SOURCE_MAC_ADDRESS_LO: source_mac_address_q[31:0] <= bus_wdata;
        acm_pkg::OFS_SOURCE_MAC_ADDRESS_HI: source_mac_address_q[47:32] <= bus_wdata[15:0];
        acm_pkg::OFS_DESTINATION_MAC_ADDRESS_LO: destination_mac_address_q[31:0] <= bus_wdata;
        acm_pkg::OFS_DESTINATION_MAC_ADDRESS_HI: destination_mac_address_q[47:32] <= bus_wdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Criterion evaluation
  // ----------------------------------------------------------------
  logic ttl_ok, frag_ok, opt_ok, sip_ok, dip_ok, is_frag;

  assign is_frag = frm_more_frags || (frm_frag_offset != 13'h0000);

  acm_tri_check u_ttl (.mode(ttl_m), .cond(frm_ttl != 8'h00), .ok(ttl_ok));
  acm_tri_check u_frag (.mode(frag_m), .cond(is_frag), .ok(frag_ok));
  acm_tri_check u_opt (.mode(opt_m), .cond(frm_has_options), .ok(opt_ok));
  acm_addr_cmp #(.W(32)) u_sip (
    .mode(sip_m),
    .frame_addr(frm_source_ip_address),
    .cfg_addr(sip_q),
    .cfg_mask(sip_mask_q),
    .ok(sip_ok)
  );
  acm_addr_cmp #(.W(32)) u_dip (
    .mode(dip_m),
    .frame_addr(frm_destination_ip_address),
    .cfg_addr(dip_q),
    .cfg_mask(dip_mask_q),
    .ok(dip_ok)
  );

  function automatic logic tri_on(input logic [1:0] m);
    tri_on = (m == acm_pkg::TRI_NO) || (m == acm_pkg::TRI_YES);
  endfunction

  function automatic logic ipm_on(input logic [1:0] m);
    ipm_on = (m == acm_pkg::IPM_HOST) || (m == acm_pkg::IPM_NET);
  endfunction

  logic ftype_ok, proto_ok, ip_need, ip_ok, source_mac_address_ok, destination_mac_address_ok;
  logic is_bc, is_mc, is_uc, vid_ok, pcp_ok, hit_c;

  assign is_bc = (frm_destination_mac_address == acm_pkg::MAC_BCAST);
  assign is_mc = frm_destination_mac_address[acm_pkg::MAC_GROUP_BIT] && !is_bc;
  assign is_uc = !frm_destination_mac_address[acm_pkg::MAC_GROUP_BIT];

  always_comb begin
    case (ftype_m)
      acm_pkg::FT_ETYPE: ftype_ok = !frm_is_ipv4 && !frm_is_arp;
      acm_pkg::FT_ARP: ftype_ok = frm_is_arp;
      acm_pkg::FT_IPV4: ftype_ok = frm_is_ipv4;
      default: ftype_ok = 1'b1;
    endcase
  end

  always_comb begin
    case (proto_m)
      acm_pkg::PR_SPEC: proto_ok = (frm_ip_proto == proto_val_q);
      acm_pkg::PR_ICMP: proto_ok = (frm_ip_proto == acm_pkg::IPP_ICMP);
      acm_pkg::PR_UDP: proto_ok = (frm_ip_proto == acm_pkg::IPP_UDP);
      acm_pkg::PR_TCP: proto_ok = (frm_ip_proto == acm_pkg::IPP_TCP);
      default: proto_ok = 1'b1;
    endcase
  end

  // IPv4 criteria need IPv4
  // Unused protocol codes behave as don't-care
  assign ip_need = (proto_m inside {acm_pkg::PR_SPEC, acm_pkg::PR_ICMP, acm_pkg::PR_UDP,
                   acm_pkg::PR_TCP}) || tri_on(ttl_m) || tri_on(frag_m)
                   || tri_on(opt_m) || ipm_on(sip_m) || ipm_on(dip_m);
  assign ip_ok = !ip_need || frm_is_ipv4;

  assign source_mac_address_ok = !source_mac_address_m || !((ftype_m == acm_pkg::FT_ETYPE) || (ftype_m == acm_pkg::FT_ARP))
                   || (frm_source_mac_address == source_mac_address_q);

  always_comb begin
    case (destination_mac_address_m)
      acm_pkg::DM_MC: destination_mac_address_ok = is_mc;
      acm_pkg::DM_BC: destination_mac_address_ok = is_bc;
      acm_pkg::DM_UC: destination_mac_address_ok = is_uc;
      acm_pkg::DM_SPEC: destination_mac_address_ok = (frm_destination_mac_address == destination_mac_address_q);
      default: destination_mac_address_ok = 1'b1;
    endcase
  end

  assign vid_ok = !vid_m || (frm_vid == vid_val_q);
  assign pcp_ok = !pcp_m || (frm_pcp == pcp_val_q);

  assign hit_c = ftype_ok && ip_ok && proto_ok && ttl_ok && frag_ok && opt_ok && sip_ok
                 && dip_ok && source_mac_address_ok && destination_mac_address_ok && vid_ok && pcp_ok;

  // ----------------------------------------------------------------
  // Result and status
  // ----------------------------------------------------------------
  // one result per frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hit_valid_q <= 1'b0;
      hit_q <= 1'b0;
      last_ipv4_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      hit_valid_q <= frm_valid;
      if (frm_valid) begin
        hit_q <= hit_c;
        last_ipv4_q <= frm_is_ipv4;
        seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      l4_sel_q <= 3'h0;
    end else begin
      l4_sel_q <= {proto_m == acm_pkg::PR_TCP, proto_m == acm_pkg::PR_UDP,
                   proto_m == acm_pkg::PR_ICMP};
    end
  end

  // Counters; a count in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frames_q <= '0;
      hits_q <= '0;
    end else begin
      if (bus_wr && bus_addr == acm_pkg::OFS_FRAMES) begin
        frames_q <= COUNT_W'(frm_valid);
      end else if (frm_valid) begin
        frames_q <= frames_q + COUNT_W'(1);
      end
      if (bus_wr && bus_addr == acm_pkg::OFS_HITS) begin
        hits_q <= COUNT_W'(frm_valid && hit_c);
      end else if (frm_valid && hit_c) begin
        hits_q <= hits_q + COUNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata_q <= 32'h00000000;
    end else if (bus_rd) begin
      case (bus_addr)
        acm_pkg::OFS_CTRL: bus_rdata_q <= 32'(ctrl_q);
        acm_pkg::OFS_MATCH: bus_rdata_q <= {4'h0, vid_val_q, 5'h00, pcp_val_q, proto_val_q};
        acm_pkg::OFS_SIP: bus_rdata_q <= sip_q;
        acm_pkg::OFS_SIP_MASK: bus_rdata_q <= sip_mask_q;
        acm_pkg::OFS_DIP: bus_rdata_q <= dip_q;
        acm_pkg::OFS_DIP_MASK: bus_rdata_q <= dip_mask_q;
        acm_pkg::OFS_SOURCE_MAC_ADDRESS_LO: bus_rdata_q <= source_mac_address_q[31:0];
        acm_pkg::OFS_SOURCE_MAC_ADDRESS_HI: bus_rdata_q <= {16'h0000, source_mac_address_q[47:32]};
        acm_pkg::OFS_DESTINATION_MAC_ADDRESS_LO: bus_rdata_q <= destination_mac_address_q[31:0];
        acm_pkg::OFS_DESTINATION_MAC_ADDRESS_HI: bus_rdata_q <= {16'h0000, destination_mac_address_q[47:32]};
        acm_pkg::OFS_STATUS: bus_rdata_q <= {29'h00000000, seen_q, last_ipv4_q, hit_q};
        acm_pkg::OFS_FRAMES: bus_rdata_q <= 32'(frames_q);
        acm_pkg::OFS_HITS: bus_rdata_q <= 32'(hits_q);
        default: bus_rdata_q <= 32'h00000000;
      endcase
    end else begin
      bus_rdata_q <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_frame_taken;
    frm_valid ##1 hit_valid_q;
  endsequence

  sequence s_miss_after;
    ##1 (hit_valid_q && !hit_q);
  endsequence

  a_result_once: assert property (!frm_valid |=> !hit_valid_q)
    else $error("result without frame");
  a_result_timing: assert property (frm_valid |-> s_frame_taken)
    else $error("frame gave no result");
  a_proto_specific: assert property (frm_valid && proto_m == acm_pkg::PR_SPEC
      && frm_ip_proto != proto_val_q |-> s_miss_after)
    else $error("protocol mismatch hit");
  a_proto_tcp: assert property (frm_valid && proto_m == acm_pkg::PR_TCP
      && frm_ip_proto != acm_pkg::IPP_TCP |-> s_miss_after)
    else $error("non TCP frame hit");
  a_l4_select: assert property (proto_m == acm_pkg::PR_UDP |=> l4_sel_q == 3'h2)
    else $error("UDP extra fields not enabled");
  a_ttl_zero: assert property (frm_valid && ttl_m == acm_pkg::TRI_NO
      && frm_ttl != 8'h00 |-> s_miss_after)
    else $error("nonzero TTL hit zero setting");
  a_frag_no: assert property (frm_valid && frag_m == acm_pkg::TRI_NO
      && (frm_more_frags || frm_frag_offset != 13'h0000) |-> s_miss_after)
    else $error("fragment hit no setting");
  a_opt_yes: assert property (frm_valid && opt_m == acm_pkg::TRI_YES
      && !frm_has_options |-> s_miss_after)
    else $error("frame without options hit yes setting");
  a_sip_net: assert property (frm_valid && sip_m == acm_pkg::IPM_NET
      && ((frm_source_ip_address ^ sip_q) & sip_mask_q) != 32'h00000000 |-> s_miss_after)
    else $error("masked source mismatch hit");
  a_dip_host: assert property (frm_valid && dip_m == acm_pkg::IPM_HOST
      && frm_destination_ip_address != dip_q |-> s_miss_after)
    else $error("destination host mismatch hit");
  a_bcast_class: assert property (frm_valid && destination_mac_address_m == acm_pkg::DM_BC
      && frm_destination_mac_address != acm_pkg::MAC_BCAST |-> s_miss_after)
    else $error("non broadcast hit");
  a_mcast_class: assert property (frm_valid && destination_mac_address_m == acm_pkg::DM_MC
      && frm_destination_mac_address == acm_pkg::MAC_BCAST |-> s_miss_after)
    else $error("broadcast hit multicast class");
  a_vid_match: assert property (frm_valid && vid_m && frm_vid != vid_val_q
      |-> s_miss_after)
    else $error("VLAN ID mismatch hit");
  a_vid_range: assert property (vid_val_q != acm_pkg::VID_NONE)
    else $error("VLAN ID zero configured");
  a_non_ipv4: assert property (frm_valid && !frm_is_ipv4 && ipm_on(sip_m)
      |-> s_miss_after)
    else $error("non IPv4 frame hit IP entry");
  a_all_any: assert property (frm_valid && ctrl_q == '0 |=> hit_q)
    else $error("all don't-care entry missed");
endmodule
`default_nettype wire

/* File: inc/acm_pkg.sv */
package acm_pkg;
  // ----------------------------------------------------------------
  // Register map and layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MATCH = 8'h04;
  localparam logic [7:0] OFS_SIP = 8'h08;
  localparam logic [7:0] OFS_SIP_MASK = 8'h0c;
  localparam logic [7:0] OFS_DIP = 8'h10;
  localparam logic [7:0] OFS_DIP_MASK = 8'h14;
  localparam logic [7:0] OFS_SOURCE_MAC_ADDRESS_LO = 8'h18;
  localparam logic [7:0] OFS_SOURCE_MAC_ADDRESS_HI = 8'h1c;
  localparam logic [7:0] OFS_DESTINATION_MAC_ADDRESS_LO = 8'h20;
  localparam logic [7:0] OFS_DESTINATION_MAC_ADDRESS_HI = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_FRAMES = 8'h2c;
  localparam logic [7:0] OFS_HITS = 8'h30;
  // Control word field positions
  localparam int unsigned POS_FTYPE = 0;
  localparam int unsigned POS_PROTO = 2;
  localparam int unsigned POS_TTL = 5;
  localparam int unsigned POS_FRAG = 7;
  localparam int unsigned POS_OPT = 9;
  localparam int unsigned POS_SIP = 11;
  localparam int unsigned POS_DIP = 13;
  localparam int unsigned POS_SOURCE_MAC_ADDRESS = 15;
  localparam int unsigned POS_DESTINATION_MAC_ADDRESS = 16;
  localparam int unsigned POS_VID = 19;
  localparam int unsigned POS_PCP = 20;
  localparam int unsigned CTRL_W = 21;
  // Match word field positions
  localparam int unsigned POS_PROTO_VAL = 0;
  localparam int unsigned POS_PCP_VAL = 8;
  localparam int unsigned POS_VID_VAL = 16;
  // Status word field positions
  localparam int unsigned POS_ST_HIT = 0;
  localparam int unsigned POS_ST_IPV4 = 1;
  localparam int unsigned POS_ST_SEEN = 2;
  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 21'h000000;
  localparam logic [7:0] RST_PROTO_VAL = 8'h00;
  localparam logic [2:0] RST_PCP_VAL = 3'h0;
  localparam logic [11:0] RST_VID_VAL = 12'h001;
  localparam logic [31:0] RST_IP = 32'h00000000;
  localparam logic [47:0] RST_MAC = 48'h000000000000;
  // ----------------------------------------------------------------
  // Criterion encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FT_ANY = 2'h0;
  localparam logic [1:0] FT_ETYPE = 2'h1;
  localparam logic [1:0] FT_ARP = 2'h2;
  localparam logic [1:0] FT_IPV4 = 2'h3;
  localparam logic [2:0] PR_ANY = 3'h0;
  localparam logic [2:0] PR_SPEC = 3'h1;
  localparam logic [2:0] PR_ICMP = 3'h2;
  localparam logic [2:0] PR_UDP = 3'h3;
  localparam logic [2:0] PR_TCP = 3'h4;
  localparam logic [1:0] TRI_ANY = 2'h0;
  localparam logic [1:0] TRI_NO = 2'h1;
  localparam logic [1:0] TRI_YES = 2'h2;
  localparam logic [1:0] IPM_ANY = 2'h0;
  localparam logic [1:0] IPM_HOST = 2'h1;
  localparam logic [1:0] IPM_NET = 2'h2;
  localparam logic [2:0] DM_ANY = 3'h0;
  localparam logic [2:0] DM_MC = 3'h1;
  localparam logic [2:0] DM_BC = 3'h2;
  localparam logic [2:0] DM_UC = 3'h3;
  localparam logic [2:0] DM_SPEC = 3'h4;
  localparam logic [7:0] IPP_ICMP = 8'h01;
  localparam logic [7:0] IPP_TCP = 8'h06;
  localparam logic [7:0] IPP_UDP = 8'h11;
  localparam logic [11:0] VID_NONE = 12'h000;
  localparam logic [47:0] MAC_BCAST = 48'hffffffffffff;
  localparam int unsigned MAC_GROUP_BIT = 40;
endpackage

/* File: verilog/acm_tri_check.sv */
`timescale 1ns/1ps
`default_nettype none
module acm_tri_check (
  input wire logic [1:0] mode,
  input wire logic cond,
  output logic ok
);
  always_comb begin
    case (mode)
      acm_pkg::TRI_NO: ok = !cond;
      acm_pkg::TRI_YES: ok = cond;
      default: ok = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/acm_addr_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module acm_addr_cmp #(
  parameter int W = 32
) (
  input wire logic [1:0] mode,
  input wire logic [W-1:0] frame_addr,
  input wire logic [W-1:0] cfg_addr,
  input wire logic [W-1:0] cfg_mask,
  output logic ok
);
  if (W < 1) begin : g_bad_width
    $error("acm_addr_cmp: width must be positive");
  end
  always_comb begin
    case (mode)
      acm_pkg::IPM_HOST: ok = (frame_addr == cfg_addr);
      acm_pkg::IPM_NET: ok = (((frame_addr ^ cfg_addr) & cfg_mask) == '0);
      default: ok = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

/* File: testbench/acm_frame.svh */
`ifndef ACM_FRAME_SVH
`define ACM_FRAME_SVH
typedef struct packed {
  logic v4;
  logic arp;
  logic [7:0] proto;
  logic [7:0] ttl;
  logic mf;
  logic [12:0] off;
  logic opt;
  logic [31:0] source_ip_address;
  logic [31:0] destination_ip_address;
  logic [47:0] source_mac_address;
  logic [47:0] destination_mac_address;
  logic [11:0] vid;
  logic [2:0] pcp;
} acm_frame_t;
`endif

/* File: testbench/acm_frame_src.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acm_frame.svh"
module acm_frame_src (
  input wire logic clk,
  output logic frm_valid,
  output logic frm_is_ipv4,
  output logic frm_is_arp,
  output logic [7:0] frm_ip_proto,
  output logic [7:0] frm_ttl,
  output logic frm_more_frags,
  output logic [12:0] frm_frag_offset,
  output logic frm_has_options,
  output logic [31:0] frm_source_ip_address,
  output logic [31:0] frm_destination_ip_address,
  output logic [47:0] frm_source_mac_address,
  output logic [47:0] frm_destination_mac_address,
  output logic [11:0] frm_vid,
  output logic [2:0] frm_pcp
);
  acm_frame_t cur_q;
  initial begin
    frm_valid = 1'b0;
    cur_q = '0;
  end
  assign {frm_is_ipv4, frm_is_arp, frm_ip_proto, frm_ttl, frm_more_frags, frm_frag_offset,
    frm_has_options, frm_source_ip_address, frm_destination_ip_address,
    frm_source_mac_address, frm_destination_mac_address, frm_vid, frm_pcp} = cur_q;
  // Called just after a rising edge; fields scrambled once the strobe drops
  task automatic send(input acm_frame_t a, input acm_frame_t b, input bit two);
    frm_valid <= 1'b1;
    cur_q <= a;
    @(posedge clk);
    if (two) begin
      cur_q <= b;
      @(posedge clk);
    end
    frm_valid <= 1'b0;
    cur_q <= ~cur_q;
  endtask
endmodule
`default_nettype wire

/* File: testbench/acm_entry_matcher_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acm_frame.svh"
module acm_entry_matcher_tb;
  logic clk;
  logic reset_n;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata_q;
  logic frm_valid, frm_is_ipv4, frm_is_arp, frm_more_frags, frm_has_options;
  logic [7:0] frm_ip_proto, frm_ttl;
  logic [12:0] frm_frag_offset;
  logic [31:0] frm_source_ip_address, frm_destination_ip_address;
  logic [47:0] frm_source_mac_address, frm_destination_mac_address;
  logic [11:0] frm_vid;
  logic [2:0] frm_pcp, l4_sel_q;
  logic hit_valid_q, hit_q;
  int err_total = 0;
  int check_count = 0;
  int n_res = 0;
  acm_frame_t f;
  acm_entry_matcher DUT (.clk, .reset_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q,
    .frm_valid, .frm_is_ipv4, .frm_is_arp, .frm_ip_proto, .frm_ttl, .frm_more_frags,
    .frm_frag_offset, .frm_has_options, .frm_source_ip_address, .frm_destination_ip_address,
    .frm_source_mac_address, .frm_destination_mac_address, .frm_vid, .frm_pcp,
    .hit_valid_q, .hit_q, .l4_sel_q);
  acm_frame_src u_src (.clk, .frm_valid, .frm_is_ipv4, .frm_is_arp, .frm_ip_proto, .frm_ttl,
    .frm_more_frags, .frm_frag_offset, .frm_has_options, .frm_source_ip_address,
    .frm_destination_ip_address, .frm_source_mac_address, .frm_destination_mac_address,
    .frm_vid, .frm_pcp);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (hit_valid_q === 1'b1) n_res <= n_res + 1;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string n, input logic [47:0] s, input logic [47:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    check("rdata", bus_rdata_q, x);
  endtask
  task automatic cfg(input logic [31:0] d);
    wr(acm_pkg::OFS_CTRL, d);
  endtask
  task automatic base;
    f = '0;
    f.v4 = 1'b1;
    f.ttl = 8'h40;
    f.destination_mac_address = 48'h020000000001;
    f.vid = 12'h001;
  endtask
  task automatic frame(input logic e);
    @(posedge clk);
    u_src.send(f, f, 1'b0);
    #1;
    check("hit_valid", hit_valid_q, 1'b1);
    check("hit", hit_q, e);
  endtask
  task automatic ip(input int s, input logic [31:0] v, input logic e);
    base();
    if (s == 1) f.destination_ip_address = v;
    else f.source_ip_address = v;
    frame(e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(acm_pkg::OFS_CTRL, 32'h0);
    rd(acm_pkg::OFS_MATCH, 32'h00010000);
    @(posedge clk);
    #1;
    check("rdata idle", bus_rdata_q, 48'h0);
    rd(8'h3c, 32'h0);
    base();
    f.v4 = 1'b0;
    frame(1'b1);
    $display("reset defaults done");
  endtask
  task automatic t_proto;
    logic [2:0] md[3] = '{acm_pkg::PR_ICMP, acm_pkg::PR_UDP, acm_pkg::PR_TCP};
    logic [7:0] pr[3] = '{acm_pkg::IPP_ICMP, acm_pkg::IPP_UDP, acm_pkg::IPP_TCP};
    cfg(32'(acm_pkg::PR_SPEC) << acm_pkg::POS_PROTO);
    wr(acm_pkg::OFS_MATCH, 32'h0001002f);
    base();
    f.proto = 8'h2f;
    frame(1'b1);
    f.proto = 8'h2e;
    frame(1'b0);
    f.proto = 8'h2f;
    f.v4 = 1'b0;
    frame(1'b0);
    for (int m = 0; m < 3; m++) begin
      cfg(32'(md[m]) << acm_pkg::POS_PROTO);
      @(posedge clk);
      #1;
      check("l4_sel", l4_sel_q, 3'h1 << m);
      base();
      f.proto = pr[m];
      frame(1'b1);
      f.proto = pr[(m + 1) % 3];
      frame(1'b0);
    end
    cfg(32'h0);
    base();
    f.proto = 8'hff;
    frame(1'b1);
    $display("protocol done");
  endtask
  task automatic t_tri;
    logic [1:0] tm[3] = '{acm_pkg::TRI_ANY, acm_pkg::TRI_NO, acm_pkg::TRI_YES};
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 3; m++) begin
        cfg(32'(tm[m]) << (acm_pkg::POS_TTL + 2 * k));
        for (int c = 0; c < 2; c++) begin
          base();
          if (k == 0) f.ttl = c[0] ? 8'h01 : 8'h00;
          else if (k == 2) f.opt = c[0];
          else if (m == 1) f.mf = c[0];
          else f.off = 13'(c);
          frame(m == 0 || ((m == 2) == c[0]));
        end
      end
    end
    $display("ttl fragment options done");
  endtask
  task automatic t_ip;
    for (int s = 0; s < 2; s++) begin
      wr(acm_pkg::OFS_SIP + 8'(8 * s), 32'hc0a80a05);
      wr(acm_pkg::OFS_SIP_MASK + 8'(8 * s), 32'hffffff00);
      cfg(32'(acm_pkg::IPM_HOST) << (acm_pkg::POS_SIP + 2 * s));
      ip(s, 32'hc0a80a05, 1'b1);
      ip(s, 32'hc0a80a04, 1'b0);
      cfg(32'(acm_pkg::IPM_NET) << (acm_pkg::POS_SIP + 2 * s));
      ip(s, 32'hc0a80aff, 1'b1);
      ip(s, 32'hc0a90a05, 1'b0);
    end
    $display("address done");
  endtask
  task automatic t_mac;
    logic [2:0] dm[3] = '{acm_pkg::DM_MC, acm_pkg::DM_BC, acm_pkg::DM_UC};
    logic [47:0] mc[3] = '{48'h01005e000001, acm_pkg::MAC_BCAST, 48'h020000000001};
    for (int m = 0; m < 3; m++) begin
      cfg(32'(dm[m]) << acm_pkg::POS_DESTINATION_MAC_ADDRESS);
      for (int j = 0; j < 3; j++) begin
        base();
        f.destination_mac_address = mc[j];
        frame(m == j);
      end
    end
    wr(acm_pkg::OFS_DESTINATION_MAC_ADDRESS_LO, 32'h00000001);
    wr(acm_pkg::OFS_DESTINATION_MAC_ADDRESS_HI, 32'h00000200);
    cfg(32'(acm_pkg::DM_SPEC) << acm_pkg::POS_DESTINATION_MAC_ADDRESS);
    base();
    frame(1'b1);
    f.destination_mac_address = 48'h030000000001;
    frame(1'b0);
    wr(acm_pkg::OFS_SOURCE_MAC_ADDRESS_LO, 32'h33445566);
    wr(acm_pkg::OFS_SOURCE_MAC_ADDRESS_HI, 32'h00001122);
    cfg((32'h1 << acm_pkg::POS_SOURCE_MAC_ADDRESS) | 32'(acm_pkg::FT_ETYPE));
    base();
    f.v4 = 1'b0;
    f.source_mac_address = 48'h112233445566;
    frame(1'b1);
    f.source_mac_address = 48'h112233445567;
    frame(1'b0);
    cfg(32'h1 << acm_pkg::POS_SOURCE_MAC_ADDRESS);
    frame(1'b1);
    cfg((32'h1 << acm_pkg::POS_SOURCE_MAC_ADDRESS) | 32'(acm_pkg::FT_ARP));
    f.arp = 1'b1;
    frame(1'b0);
    f.source_mac_address = 48'h112233445566;
    frame(1'b1);
    f.arp = 1'b0;
    frame(1'b0);
    cfg(32'(acm_pkg::FT_IPV4));
    frame(1'b0);
    f.v4 = 1'b1;
    frame(1'b1);
    $display("mac done");
  endtask
  task automatic t_vlan;
    wr(acm_pkg::OFS_MATCH, 32'h0fff0700);
    rd(acm_pkg::OFS_MATCH, 32'h0fff0700);
    cfg((32'h1 << acm_pkg::POS_VID) | (32'h1 << acm_pkg::POS_PCP));
    base();
    f.vid = 12'hfff;
    f.pcp = 3'h7;
    frame(1'b1);
    f.vid = 12'hffe;
    frame(1'b0);
    f.vid = 12'hfff;
    f.pcp = 3'h6;
    frame(1'b0);
    wr(acm_pkg::OFS_MATCH, 32'h00000600);
    rd(acm_pkg::OFS_MATCH, 32'h0fff0600);
    $display("vlan done");
  endtask
  task automatic t_b2b;
    acm_frame_t g;
    int n0;
    wr(acm_pkg::OFS_FRAMES, 32'h0);
    wr(acm_pkg::OFS_HITS, 32'h0);
    cfg(32'h1 << acm_pkg::POS_VID);
    base();
    f.vid = 12'hfff;
    g = f;
    g.vid = 12'h001;
    @(posedge clk);
    n0 = n_res;
    u_src.send(f, g, 1'b1);
    #1;
    check("hit", hit_q, 1'b0);
    @(posedge clk);
    #1;
    check("results", 48'(n_res - n0), 48'd2);
    rd(acm_pkg::OFS_FRAMES, 32'h2);
    rd(acm_pkg::OFS_HITS, 32'h1);
    rd(acm_pkg::OFS_STATUS, 32'h6);
    $display("back to back done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {reset_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_proto();
    t_tri();
    t_ip();
    t_mac();
    t_vlan();
    t_b2b();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
